// [hw/aux_pointer_update.sv]
// module: next value of an auxiliary register, with bit reversal and circular wrap
`timescale 1ns/1ps
`default_nettype none
module aux_pointer_update (
   aux_update_if.updater upd // update request and answer
);
   import operand_loop_pkg::*;

   // mirror a word end for end so that carries ripple downward
   function automatic word_t reverseBits(input word_t w);
      word_t r;
      r = WORD_ZERO;
      for (int i = 0; i < 16; i++) begin
         r[i] = w[15-i];
      end
      return r;
   endfunction

   word_t plain;
   logic  goingUp;

   ////////////////////////////////////////////////////////////////////////////
   // arithmetic for the seven variants
   always_comb begin
      goingUp = 1'b0;
      unique case (upd.updateMode)
         UPD_NONE: plain = upd.arValue;
         UPD_INC: begin
            plain = upd.arValue + WORD_ONE;
            goingUp = 1'b1;
         end
         UPD_DEC:  plain = upd.arValue - WORD_ONE;
         UPD_ADD0: begin
            plain = upd.arValue + upd.indexValue;
            goingUp = 1'b1;
         end
         UPD_SUB0: plain = upd.arValue - upd.indexValue;
         UPD_RINC: begin
            plain = reverseBits(reverseBits(upd.arValue) + reverseBits(upd.indexValue));
            goingUp = 1'b1;
         end
         UPD_RDEC: plain = reverseBits(reverseBits(upd.arValue) - reverseBits(upd.indexValue));
         default:  plain = upd.arValue;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // wrap at the buffer edges
   always_comb begin
      upd.arNext = plain;
      if (upd.circEnable && upd.updateMode != UPD_NONE) begin
         if (goingUp && upd.arValue == upd.circEnd) begin
            upd.arNext = upd.circStart;
         end else if (!goingUp && upd.arValue == upd.circStart) begin
            upd.arNext = upd.circEnd;
         end
      end
   end

endmodule // aux_pointer_update
`default_nettype wire

// [hw/aux_update_if.sv]
// interface: pointer update request and answer between core and update unit
`timescale 1ns/1ps
`default_nettype none
interface aux_update_if;
   import operand_loop_pkg::*;
   word_t     arValue;   // pointer before update
   word_t     indexValue; // index register contents
   upd_mode_t updateMode; // update variant
   logic      circEnable; // pointer belongs to an enabled buffer
   word_t     circStart;  // buffer first location
   word_t     circEnd;    // buffer last location
   word_t     arNext;     // pointer after update
   modport requester (output arValue, indexValue, updateMode, circEnable, circStart, circEnd,
                      input arNext);
   modport updater (input arValue, indexValue, updateMode, circEnable, circStart, circEnd,
                    output arNext);
endinterface // aux_update_if
`default_nettype wire

// [hw/operand_address_and_loop_control.sv]
// module: operand address generation, single repeat and block repeat control
`timescale 1ns/1ps
`default_nettype none
module operand_address_and_loop_control (
   input  wire  logic                        core_clk,      // core clock
   input  wire  logic                        reset_n,       // sync reset, low
   input  wire  logic                        opValid,       // operand access this cycle
   input  wire  operand_loop_pkg::addr_mode_t addrMode,     // addressing mode
   input  wire  operand_loop_pkg::word_t     instrWord,     // first instruction word
   input  wire  operand_loop_pkg::word_t     instrWord2,    // second instruction word
   input  wire  operand_loop_pkg::upd_mode_t indUpdate,     // indirect update variant
   input  wire  logic                        dpLoad,        // load page pointer
   input  wire  logic [8:0]                  dpValue,       // new page pointer
   input  wire  logic                        arpLoad,       // load register selector
   input  wire  logic [2:0]                  arpValue,      // new selector
   input  wire  logic                        arWrite,       // load an aux register
   input  wire  logic [2:0]                  arWriteIdx,    // which aux register
   input  wire  operand_loop_pkg::word_t     arWriteValue,  // value to load
   input  wire  logic                        circWrite,     // load a circular register
   input  wire  operand_loop_pkg::circ_sel_t circSel,       // which circular register
   input  wire  operand_loop_pkg::word_t     circValue,     // value to load
   input  wire  logic                        rptIssue,      // repeat single decoded
   input  wire  logic                        rptzIssue,     // repeat with clear decoded
   input  wire  operand_loop_pkg::word_t     rptCount,      // repeat count N
   input  wire  logic                        iterDone,      // one execution finished
   input  wire  logic                        holdReq,       // external hold request
   input  wire  logic                        brcrWrite,     // load block count
   input  wire  operand_loop_pkg::word_t     brcrValue,     // block count value
   input  wire  logic                        rptbIssue,     // block repeat executed
   input  wire  operand_loop_pkg::word_t     rptbNextPc,    // address after it
   input  wire  logic                        pcUpdate,      // PC advances
   input  wire  operand_loop_pkg::word_t     pcValue,       // PC being updated
   input  wire  logic                        brafWrite,     // software flag write
   input  wire  logic                        brafValue,     // flag value
   output var   operand_loop_pkg::word_t     operandAddr,   // data address, reg
   output var   operand_loop_pkg::word_t     immOperand,    // immediate, reg
   output logic                              periphStall,   // extra cycle request
   output logic                              irqMask,       // mask all interrupts
   output logic                              clearSumProduct, // zero sum and product
   output logic                              repeatActive,  // single repeat running
   output logic                              repeatPipelined, // one cycle per iteration
   output logic                              holdAck,       // hold acknowledged
   output logic                              pcRedirect,    // load PC from start
   output var   operand_loop_pkg::word_t     pcRedirectAddr, // block start address
   output logic                              blockActive,   // block repeat flag
   output var   operand_loop_pkg::word_t     blockCount,    // block count
   output var   operand_loop_pkg::word_t     repeatCounter, // single repeat counter
   output logic [8:0]                        dataPagePointer, // page pointer
   output logic [2:0]                        auxRegSelect   // register selector
);
   import operand_loop_pkg::*;

   typedef struct packed {
      logic [PAGE_W-1:0]         dataPagePointer;
      logic [SEL_W-1:0]          auxRegSelect;
      logic [AR_COUNT-1:0][15:0] auxRegisters;
      word_t                     operandAddr;
      word_t                     immOperand;
      word_t                     singleRepeatCounter;
      logic                      repeatActive;
      logic                      repeatPipelined;
      logic                      clearSumProduct;
      logic                      holdAck;
      logic                      stallDone;
      word_t                     blockRepeatCount;
      word_t                     blockStartAddress;
      word_t                     blockEndAddress;
      logic                      blockRepeatActiveFlag;
      word_t                     circStart1;
      word_t                     circEnd1;
      word_t                     circStart2;
      word_t                     circEnd2;
      logic [7:0]                circControl;
   } state_t;

   state_t state_reg;
   state_t state_next;
   word_t  effAddr;
   word_t  immValue;
   logic   isImm;
   logic   inPeriph;
   logic   opTake;
   logic   atEnd;
   logic   loopBack;
   logic   circHit1;
   logic   circHit2;

   aux_update_if upd ();

   aux_pointer_update u_update (
      .upd (upd.updater)
   );

   ////////////////////////////////////////////////////////////////////////////
   // effective address and immediate for the current mode
   always_comb begin
      effAddr  = WORD_ZERO;
      immValue = WORD_ZERO;
      isImm    = 1'b0;
      unique case (addrMode)
         MODE_DIRECT:   effAddr = {state_reg.dataPagePointer, instrWord[OFFS_W-1:0]};
         MODE_INDIRECT: effAddr = state_reg.auxRegisters[state_reg.auxRegSelect];
         MODE_MMAP:     effAddr = {PAGE_ZERO, instrWord[OFFS_W-1:0]};
         MODE_SHORT: begin
            isImm    = 1'b1;
            immValue = {SHORT_PAD, instrWord[SHORT_W-1:0]};
         end
         MODE_LONG: begin
            isImm    = 1'b1;
            immValue = instrWord2;
         end
         default: ;
      endcase
   end

   // peripheral window costs one stall cycle per access
   assign inPeriph    = !isImm && effAddr >= PERIPH_LO && effAddr <= PERIPH_HI;
   assign periphStall = opValid && inPeriph && !state_reg.stallDone;
   assign opTake      = opValid && !periphStall;

   ////////////////////////////////////////////////////////////////////////////
   // pointer update request: find whether the pointer feeds a circular buffer
   assign circHit1 = state_reg.circControl[CBC_EN1] &&
                     state_reg.circControl[CBC_AR1_LSB +: SEL_W] == state_reg.auxRegSelect;
   assign circHit2 = state_reg.circControl[CBC_EN2] &&
                     state_reg.circControl[CBC_AR2_LSB +: SEL_W] == state_reg.auxRegSelect;
   assign upd.arValue    = state_reg.auxRegisters[state_reg.auxRegSelect];
   assign upd.indexValue = state_reg.auxRegisters[0];
   assign upd.updateMode = indUpdate;
   assign upd.circEnable = circHit1 || circHit2;
   assign upd.circStart  = circHit1 ? state_reg.circStart1 : state_reg.circStart2;
   assign upd.circEnd    = circHit1 ? state_reg.circEnd1 : state_reg.circEnd2;

   // block loop end test on each PC update
   assign atEnd    = state_reg.blockRepeatActiveFlag && pcUpdate &&
                     pcValue == state_reg.blockEndAddress;
   assign loopBack = atEnd && state_reg.blockRepeatCount != WORD_ZERO;

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      state_next = state_reg;
      state_next.clearSumProduct = 1'b0;
      state_next.holdAck   = holdReq;
      state_next.stallDone = periphStall;
      // operand capture and same-cycle pointer update
      if (opTake) begin
         if (isImm) begin
            state_next.immOperand = immValue;
         end else begin
            state_next.operandAddr = effAddr;
         end
      end
      if (arWrite) begin
         state_next.auxRegisters[arWriteIdx] = arWriteValue;
      end
      if (opTake && addrMode == MODE_INDIRECT) begin
         state_next.auxRegisters[state_reg.auxRegSelect] = upd.arNext;
      end
      if (arpLoad) begin
         state_next.auxRegSelect = arpValue;
      end
      if (dpLoad) begin
         state_next.dataPagePointer = dpValue;
      end
      // circular register loads
      if (circWrite) begin
         unique case (circSel)
            CIRC_START1: state_next.circStart1 = circValue;
            CIRC_END1:   state_next.circEnd1   = circValue;
            CIRC_START2: state_next.circStart2 = circValue;
            CIRC_END2:   state_next.circEnd2   = circValue;
            CIRC_CTRL:   state_next.circControl = circValue[7:0];
            default: ;
         endcase
      end
      // single instruction repeat
      if (rptIssue || rptzIssue) begin
         state_next.singleRepeatCounter = rptCount;
         state_next.repeatActive    = 1'b1;
         state_next.repeatPipelined = 1'b0;
         state_next.clearSumProduct = rptzIssue;
      end else if (state_reg.repeatActive && iterDone) begin
         if (state_reg.singleRepeatCounter == WORD_ZERO) begin
            state_next.repeatActive    = 1'b0;
            state_next.repeatPipelined = 1'b0;
         end else begin
            state_next.singleRepeatCounter = state_reg.singleRepeatCounter - WORD_ONE;
            state_next.repeatPipelined = 1'b1;
         end
      end
      // block repeat count and flag
      if (brcrWrite) begin
         state_next.blockRepeatCount = brcrValue;
      end else if (loopBack) begin
         state_next.blockRepeatCount = state_reg.blockRepeatCount - WORD_ONE;
      end
      if (atEnd && !loopBack) begin
         state_next.blockRepeatActiveFlag = 1'b0;
      end
      if (brafWrite) begin
         state_next.blockRepeatActiveFlag = brafValue;
      end
      if (rptbIssue) begin
         state_next.blockStartAddress = rptbNextPc;
         state_next.blockEndAddress   = instrWord2;
         state_next.blockRepeatActiveFlag = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         state_reg <= '{dataPagePointer: PAGE_ZERO, auxRegSelect: SEL_ZERO,
                        auxRegisters: '0, operandAddr: WORD_ZERO, immOperand: WORD_ZERO,
                        singleRepeatCounter: WORD_ZERO, repeatActive: 1'b0,
                        repeatPipelined: 1'b0, clearSumProduct: 1'b0, holdAck: 1'b0,
                        stallDone: 1'b0, blockRepeatCount: WORD_ZERO,
                        blockStartAddress: WORD_ZERO, blockEndAddress: WORD_ZERO,
                        blockRepeatActiveFlag: 1'b0, circStart1: WORD_ZERO,
                        circEnd1: WORD_ZERO, circStart2: WORD_ZERO, circEnd2: WORD_ZERO,
                        circControl: CTRL_ZERO};
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign operandAddr     = state_reg.operandAddr;
   assign immOperand      = state_reg.immOperand;
   assign irqMask         = rptIssue || rptzIssue || state_reg.repeatActive;
   assign clearSumProduct = state_reg.clearSumProduct;
   assign repeatActive    = state_reg.repeatActive;
   assign repeatPipelined = state_reg.repeatPipelined;
   assign holdAck         = state_reg.holdAck;
   assign pcRedirect      = loopBack;
   assign pcRedirectAddr  = state_reg.blockStartAddress;
   assign blockActive     = state_reg.blockRepeatActiveFlag;
   assign blockCount      = state_reg.blockRepeatCount;
   assign repeatCounter   = state_reg.singleRepeatCounter;
   assign dataPagePointer = state_reg.dataPagePointer;
   assign auxRegSelect    = state_reg.auxRegSelect;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence seqLoopBack;
      loopBack && !brcrWrite ##1 blockCount == $past(blockCount) - WORD_ONE;
   endsequence

   chk_direct_addr: assert property (
      opTake && addrMode == MODE_DIRECT |=>
      operandAddr == {$past(state_reg.dataPagePointer), $past(instrWord[OFFS_W-1:0])})
      else $error("direct address not page pointer over offset");
   chk_indirect_sel: assert property (
      opTake && addrMode == MODE_INDIRECT |=>
      operandAddr == $past(state_reg.auxRegisters[state_reg.auxRegSelect]))
      else $error("indirect address not from selected register");
   chk_mmap_page: assert property (
      opTake && addrMode == MODE_MMAP |=> operandAddr[15:OFFS_W] == PAGE_ZERO)
      else $error("memory-mapped access left page zero");
   chk_repeat_reset: assert property (
      $rose(reset_n) |-> repeatCounter == WORD_ZERO && !repeatActive)
      else $error("repeat counter not cleared by reset");
   chk_clear_pulse: assert property (
      rptzIssue |=> clearSumProduct ##1 !clearSumProduct)
      else $error("clear pulse missing or too long");
   chk_irq_masked: assert property (
      (rptIssue || rptzIssue) |-> irqMask ##1 (irqMask throughout repeatActive [*1]))
      else $error("interrupts not masked during repeat");
   chk_hold_resp: assert property (
      repeatActive && holdReq |=> holdAck)
      else $error("hold ignored during repeat");
   chk_repeat_count: assert property (
      repeatActive && iterDone && !rptIssue && !rptzIssue && repeatCounter != WORD_ZERO
      |=> repeatActive && repeatCounter == $past(repeatCounter) - WORD_ONE)
      else $error("repeat counter step wrong");
   chk_block_load: assert property (
      rptbIssue |=> blockActive && pcRedirectAddr == $past(rptbNextPc))
      else $error("block repeat load wrong");
   chk_block_loop: assert property (
      loopBack && !brcrWrite |-> seqLoopBack)
      else $error("block loop back wrong");
   chk_block_exit: assert property (
      atEnd && blockCount == WORD_ZERO && !rptbIssue && !brafWrite |-> !pcRedirect ##1 !blockActive)
      else $error("block flag not cleared at loop end");
   chk_periph_extra: assert property (
      periphStall |=> !periphStall)
      else $error("peripheral stall longer than one cycle");

endmodule // operand_address_and_loop_control
`default_nettype wire

// [hw/operand_loop_pkg.sv]
// package: constants and types for operand address and loop control
package operand_loop_pkg;

   localparam int PAGE_W      = 9;
   localparam int OFFS_W      = 7;
   localparam int SHORT_W     = 8;
   localparam int AR_COUNT    = 8;
   localparam int SEL_W       = 3;

   typedef logic [15:0] word_t;

   localparam word_t              WORD_ZERO = 16'h0000;
   localparam word_t              WORD_ONE  = 16'h0001;
   localparam word_t              PERIPH_LO = 16'h0020;
   localparam word_t              PERIPH_HI = 16'h004F;
   localparam logic [PAGE_W-1:0]  PAGE_ZERO = 9'h000;
   localparam logic [SEL_W-1:0]   SEL_ZERO  = 3'h0;
   localparam logic [7:0]         CTRL_ZERO = 8'h00;
   localparam logic [15-SHORT_W:0] SHORT_PAD = 8'h00;

   // circular control register layout: pointer select and enable per buffer
   localparam int CBC_AR1_LSB = 0;
   localparam int CBC_EN1     = 3;
   localparam int CBC_AR2_LSB = 4;
   localparam int CBC_EN2     = 7;

   // circular register write select
   typedef enum logic [2:0] {
      CIRC_START1 = 3'h0,
      CIRC_END1   = 3'h1,
      CIRC_START2 = 3'h2,
      CIRC_END2   = 3'h3,
      CIRC_CTRL   = 3'h4
   } circ_sel_t;

   // auxiliary register update variants
   typedef enum logic [2:0] {
      UPD_NONE = 3'h0,
      UPD_INC  = 3'h1,
      UPD_DEC  = 3'h2,
      UPD_ADD0 = 3'h3,
      UPD_SUB0 = 3'h4,
      UPD_RINC = 3'h5,
      UPD_RDEC = 3'h6
   } upd_mode_t;

   // operand addressing mode, one-hot
   typedef enum logic [4:0] {
      MODE_DIRECT   = 5'h01,
      MODE_INDIRECT = 5'h02,
      MODE_SHORT    = 5'h04,
      MODE_LONG     = 5'h08,
      MODE_MMAP     = 5'h10
   } addr_mode_t;

endpackage

// [tb/operand_address_and_loop_control_tb.sv]
// testbench: operand addressing, single repeat and block repeat
`timescale 1ns/1ps
`default_nettype none
module operand_address_and_loop_control_tb;
   import operand_loop_pkg::*;
   logic       core_clk, reset_n, opValid, dpLoad, arpLoad, arWrite, circWrite, rptIssue;
   logic       rptzIssue, iterDone, holdReq, brcrWrite, rptbIssue, pcUpdate, brafWrite;
   logic       brafValue, periphStall, irqMask, clearSumProduct, repeatActive;
   logic       repeatPipelined, holdAck, pcRedirect, blockActive;
   logic [8:0] dpValue, dataPagePointer;
   logic [2:0] arpValue, arWriteIdx, auxRegSelect;
   addr_mode_t addrMode;
   upd_mode_t  indUpdate;
   circ_sel_t  circSel;
   word_t      instrWord, instrWord2, arWriteValue, circValue, rptCount, brcrValue;
   word_t      rptbNextPc, pcValue, operandAddr, immOperand, pcRedirectAddr, blockCount;
   word_t      repeatCounter;
   int         n_errors = 0;
   int         n_tests = 0;
   operand_address_and_loop_control DUT (.*);
   ////////////////////////////////////////////////////////////////////////////////
   // clock, inputs at time zero, reset and main sequence
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      {reset_n, opValid, dpLoad, arpLoad, arWrite, circWrite, rptIssue, rptzIssue} = 8'h00;
      {iterDone, holdReq, brcrWrite, rptbIssue, pcUpdate, brafWrite, brafValue} = 7'h00;
      {dpValue, arpValue, arWriteIdx} = 15'h0000;
      {instrWord, instrWord2, arWriteValue, circValue} = 64'h0;
      {rptCount, brcrValue, rptbNextPc, pcValue} = 64'h0;
      addrMode = MODE_DIRECT;
      indUpdate = UPD_NONE;
      circSel = CIRC_START1;
      repeat (4) @(negedge core_clk);
      reset_n = 1'b1;
      chk("counter", WORD_ZERO, repeatCounter);
      t_direct();
      t_indirect();
      t_circ();
      t_imm_mmap();
      t_repeat();
      t_block();
      print_verdict();
   end
   initial begin
      #100000;
      n_errors++;
      print_verdict();
   end
   ////////////////////////////////////////////////////////////////////////////////
   // shared tasks: compare, operand access, verdict
   task automatic chk(input string nm, input word_t exp, input word_t got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic acc(input addr_mode_t m, input word_t w, input word_t w2, input upd_mode_t u,
                      output logic st);
      opValid = 1'b1;
      addrMode = m;
      instrWord = w;
      instrWord2 = w2;
      indUpdate = u;
      #1 st = periphStall;
      @(negedge core_clk);
      if (st) @(negedge core_clk); // refused first cycle, hold one more
      opValid = 1'b0;
      @(negedge core_clk); // idle edge between accesses
   endtask
   task print_verdict;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task t_direct;
      logic st;
      dpLoad = 1'b1;
      dpValue = 9'h1A5;
      @(negedge core_clk);
      dpLoad = 1'b0;
      acc(MODE_DIRECT, 16'hFFD5, WORD_ZERO, UPD_NONE, st);
      chk("direct", 16'hD2D5, operandAddr);
      chk("page", 16'h01A5, word_t'(dataPagePointer));
   endtask
   task t_indirect;
      logic st;
      {arWrite, arWriteIdx, arWriteValue, arpLoad, arpValue} = {4'hB, 16'h1234, 4'hB};
      @(negedge core_clk);
      {arWriteIdx, arWriteValue, arpLoad} = {3'h0, 16'h0010, 1'b0};
      @(negedge core_clk);
      arWrite = 1'b0;
      acc(MODE_INDIRECT, WORD_ZERO, WORD_ZERO, UPD_ADD0, st);
      chk("ind", 16'h1234, operandAddr);
      {arpLoad, arpValue} = 4'h8;
      acc(MODE_INDIRECT, WORD_ZERO, WORD_ZERO, UPD_DEC, st);
      arpLoad = 1'b0;
      chk("ind", 16'h1244, operandAddr);
      acc(MODE_INDIRECT, WORD_ZERO, WORD_ZERO, UPD_NONE, st);
      chk("ind", 16'h0010, operandAddr);
      chk("select", WORD_ZERO, word_t'(auxRegSelect));
   endtask
   task t_circ;
      logic st;
      circWrite = 1'b1;
      circSel = CIRC_START1;
      circValue = 16'h0200;
      @(negedge core_clk);
      circSel = CIRC_END1;
      circValue = 16'h0202;
      @(negedge core_clk);
      circSel = CIRC_CTRL;
      circValue = 16'h000D; // buffer 1 enabled on pointer 5
      {arWrite, arWriteIdx, arWriteValue, arpLoad, arpValue} = {4'hD, 16'h0201, 4'hD};
      @(negedge core_clk);
      {circWrite, arWrite, arpLoad} = 3'h0;
      acc(MODE_INDIRECT, WORD_ZERO, WORD_ZERO, UPD_INC, st);
      chk("circ", 16'h0201, operandAddr);
      acc(MODE_INDIRECT, WORD_ZERO, WORD_ZERO, UPD_INC, st);
      chk("circ", 16'h0202, operandAddr);
      acc(MODE_INDIRECT, WORD_ZERO, WORD_ZERO, UPD_RINC, st);
      chk("circ", 16'h0200, operandAddr);
      acc(MODE_INDIRECT, WORD_ZERO, WORD_ZERO, UPD_NONE, st);
      chk("rev", 16'h0210, operandAddr);
      chk("select", 16'h0005, word_t'(auxRegSelect));
   endtask
   task t_imm_mmap;
      logic st;
      acc(MODE_SHORT, 16'hABCD, WORD_ZERO, UPD_NONE, st);
      chk("short", 16'h00CD, immOperand);
      acc(MODE_LONG, 16'hABCD, 16'h5A5A, UPD_NONE, st);
      chk("long", 16'h5A5A, immOperand);
      acc(MODE_MMAP, 16'hFFCF, WORD_ZERO, UPD_NONE, st);
      chk("mmap", 16'h004F, operandAddr);
      chk("stall", WORD_ONE, word_t'(st));
      acc(MODE_MMAP, 16'h0050, WORD_ZERO, UPD_NONE, st);
      chk("stall", WORD_ZERO, word_t'(st));
   endtask
   task t_repeat;
      int n;
      {rptzIssue, rptCount, holdReq} = {1'b1, 16'h0001, 1'b1};
      #1 chk("mask", WORD_ONE, word_t'(irqMask));
      @(negedge core_clk);
      rptzIssue = 1'b0;
      chk("clear", WORD_ONE, word_t'(clearSumProduct));
      chk("holdAck", WORD_ONE, word_t'(holdAck));
      chk("counter", WORD_ONE, repeatCounter);
      n = 0;
      while (repeatActive === 1'b1 && n < 10) begin
         chk("mask", WORD_ONE, word_t'(irqMask));
         if (n == 1) chk("piped", WORD_ONE, word_t'(repeatPipelined));
         iterDone = 1'b1;
         @(negedge core_clk);
         n++;
      end
      {iterDone, holdReq} = 2'h0;
      chk("iterations", 16'h0002, word_t'(n));
      chk("mask", WORD_ZERO, word_t'(irqMask));
      {rptIssue, rptCount} = {1'b1, WORD_ZERO};
      @(negedge core_clk);
      rptIssue = 1'b0;
      chk("clear", WORD_ZERO, word_t'(clearSumProduct));
      chk("active", WORD_ONE, word_t'(repeatActive));
      iterDone = 1'b1;
      @(negedge core_clk);
      iterDone = 1'b0;
      chk("active", WORD_ZERO, word_t'(repeatActive));
   endtask
   task t_block;
      {brcrWrite, brcrValue} = {1'b1, WORD_ONE};
      @(negedge core_clk);
      {brcrWrite, rptbIssue, rptbNextPc, instrWord2} = {2'h1, 16'h0100, 16'h0103};
      @(negedge core_clk);
      {rptbIssue, pcUpdate, pcValue} = {2'h1, 16'h0200};
      chk("start", 16'h0100, pcRedirectAddr);
      #1 chk("redirect", WORD_ZERO, word_t'(pcRedirect));
      @(negedge core_clk);
      pcValue = 16'h0103;
      chk("flag", WORD_ONE, word_t'(blockActive));
      #1 chk("redirect", WORD_ONE, word_t'(pcRedirect));
      @(negedge core_clk);
      chk("count", WORD_ZERO, blockCount);
      #1 chk("redirect", WORD_ZERO, word_t'(pcRedirect));
      @(negedge core_clk);
      pcUpdate = 1'b0;
      chk("flag", WORD_ZERO, word_t'(blockActive));
      {brcrWrite, brcrValue} = {1'b1, 16'h0002};
      @(negedge core_clk);
      {brcrWrite, rptbIssue} = 2'h1;
      @(negedge core_clk);
      {rptbIssue, brafWrite, brafValue} = 3'h2;
      @(negedge core_clk);
      {brafWrite, pcUpdate} = 2'h1;
      chk("flag", WORD_ZERO, word_t'(blockActive));
      #1 chk("redirect", WORD_ZERO, word_t'(pcRedirect));
      @(negedge core_clk);
      pcUpdate = 1'b0;
      chk("count", 16'h0002, blockCount);
   endtask
endmodule // operand_address_and_loop_control_tb
`default_nettype wire
